// ===== logic/pds_defines.vh
// Register map, field layouts, reset values and codes for the divider and modulator block
`ifndef PDS_DEFINES_VH
`define PDS_DEFINES_VH

// Register byte offsets (APB, one aligned word each)
`define PDS_OFF_LOOP0_FB 12'h000
`define PDS_OFF_LOOP1_FB 12'h004
`define PDS_OFF_LOOP2_FB 12'h008
`define PDS_OFF_SS0_CTRL 12'h010
`define PDS_OFF_SS1_CTRL 12'h014
`define PDS_OFF_SS0_PROF_LO 12'h018
`define PDS_OFF_SS0_PROF_HI 12'h01C
`define PDS_OFF_SS1_PROF_LO 12'h020
`define PDS_OFF_SS1_PROF_HI 12'h024
`define PDS_OFF_BANK_BASE 12'h030
`define PDS_OFF_STATUS 12'h050
`define PDS_OFF_MULT0 12'h054
`define PDS_OFF_MULT1 12'h058

// Feedback register fields
`define PDS_FB_COUNT_LSB 0
`define PDS_FB_ADJ_LSB 16
// Spread control fields
`define PDS_SS_STEP_LSB 0
`define PDS_SS_QUAD_LSB 4
`define PDS_SS_OFFSET_LSB 8
`define PDS_SS_DITHER_BIT 16
`define PDS_SS_DOUBLE_BIT 17
// Bank register fields
`define PDS_BK_COUNT_LSB 0
`define PDS_BK_SEL_LSB 16

// Post-divider select codes
`define PDS_PDS_OFF 2'h0
`define PDS_PDS_DIV1 2'h1
`define PDS_PDS_DIV2 2'h2
`define PDS_PDS_CNT 2'h3

// Reset values
`define PDS_RST_FB 32'h00000000
`define PDS_RST_SS 32'h00000000
`define PDS_RST_BANK 32'h00000000

// Fixed figures
`define PDS_STEP_EXTRA 5'h02
`define PDS_POST_EXTRA 11'h002
`define PDS_NUM_SAMPLES 12
`define PDS_LFSR_SEED 8'hA5

`endif

// ===== logic/pds_top.v
// Feedback multiplier, post-divider and spread-spectrum modulator for a three-loop generator
`timescale 1ns/1ps
`include "pds_defines.vh"

// Overview of operation
// - Loops one/two multiplier is 2*count+adjust+1; adjust zero means minus one.
// - Adjust field gives even or odd integer ratios with modulation off.
// - Zero feedback count drives the oscillator to minimum frequency.
// - Banks two to six each have a 10-bit post count, 1 to 1023.
// - First output bank has no post-divider and no select bits.
// - Select: 00 off, 01 div1, 10 div2, 11 post count plus two.
// - Disabled post-divider gives no clock but the bank stays powered.
// - Each bank clock then passes a fixed divide-by-two stage.
// - Modulation active when step code and summed deltas nonzero, off when step code zero.
// - Detector cycles per step equal step code plus two; codes 5 to 14.
// - Samples per quadrant equal quadrant code times two; codes 1 to 6.
// - Four mirrored quadrants; period is four times samples times step.
// - Six-bit offset adds offset/64; zero is center, nonzero down spread.
// - Twelve 4-bit delta samples per loop; quadrant code selects how many.
// - Waveform rebuilt by accumulating deltas starting from the offset.
// - Dither bit set randomizes the modulator input least significant bit.
// - Double bit set doubles the summed deltas, doubling amplitude.
// - Nonzero step with zero deltas gives fractional multiplier plus offset/64.
// - In fractional mode the step and profile settings have no effect.
module pds_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [4:0] bank_clk_in,
  output reg [4:0] bank_clk_out,
  output reg [4:0] bank_powered,
  output reg [13:0] loop0_mult_int,
  output reg [13:0] loop1_mult_int,
  output reg [11:0] loop2_mult_int,
  output reg [7:0] loop0_mult_frac,
  output reg [7:0] loop1_mult_frac,
  output reg [2:0] loop_vco_min
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Integer part of the multiplier for loops one and two
  function [13:0] int_mult;
    input [11:0] cnt;
    input [3:0] adj;
    reg [13:0] twice;
    begin
      twice = {1'b0, cnt, 1'b0};
      if (adj == 4'h0) begin
        int_mult = twice;
      end else begin
        int_mult = twice + {10'h000, adj} + 14'h0001;
      end
    end
  endfunction

  // Nibble k of a 48-bit profile word
  function [3:0] nib;
    input [47:0] prof;
    input [3:0] k;
    begin
      nib = prof[k*4 +: 4];
    end
  endfunction

  // Sum of the first n deltas of a profile
  function [7:0] delta_sum;
    input [47:0] prof;
    input [3:0] n;
    integer i;
    begin
      delta_sum = 8'h00;
      for (i = 0; i < `PDS_NUM_SAMPLES; i = i + 1) begin
        if (i < n) begin
          delta_sum = delta_sum + {4'h0, prof[i*4 +: 4]};
        end
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [31:0] fb_q [0:2];
  reg [31:0] ss_q [0:1];
  reg [47:0] prof_q [0:1];
  reg [31:0] bank_q [0:4];

  wire setup_acc = psel & ~penable;
  wire do_acc = psel & penable & pready;
  // Bank registers sit at a base plus four times the bank index
  wire [11:0] bank_off = paddr - `PDS_OFF_BANK_BASE;
  wire [2:0] bank_idx = bank_off[4:2];
  wire is_bank = (bank_off[11:5] == 7'h00) & (bank_idx < 3'h5);

  reg mapped;
  always @* begin
    case (paddr)
      `PDS_OFF_LOOP0_FB, `PDS_OFF_LOOP1_FB, `PDS_OFF_LOOP2_FB,
      `PDS_OFF_SS0_CTRL, `PDS_OFF_SS1_CTRL, `PDS_OFF_SS0_PROF_LO,
      `PDS_OFF_SS0_PROF_HI, `PDS_OFF_SS1_PROF_LO, `PDS_OFF_SS1_PROF_HI,
      `PDS_OFF_STATUS, `PDS_OFF_MULT0, `PDS_OFF_MULT1: mapped = 1'b1;
      default: mapped = is_bank;
    endcase
  end

  // ----------------------------------------------------------------
  // APB slave: one wait state, answer in the second access cycle
  // ----------------------------------------------------------------
  reg [5:0] status_w;
  integer j;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      for (j = 0; j < 3; j = j + 1) begin
        fb_q[j] <= `PDS_RST_FB;
      end
      for (j = 0; j < 2; j = j + 1) begin
        ss_q[j] <= `PDS_RST_SS;
        prof_q[j] <= 48'h000000000000;
      end
      for (j = 0; j < 5; j = j + 1) begin
        bank_q[j] <= `PDS_RST_BANK;
      end
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (setup_acc) begin
        prdata <= 32'h00000000;
      end
      if (psel & penable & ~pready & ~pwrite) begin
        case (paddr)
          `PDS_OFF_LOOP0_FB: prdata <= {12'h000, fb_q[0][19:16], 4'h0, fb_q[0][11:0]};
          `PDS_OFF_LOOP1_FB: prdata <= {12'h000, fb_q[1][19:16], 4'h0, fb_q[1][11:0]};
          `PDS_OFF_LOOP2_FB: prdata <= {20'h00000, fb_q[2][11:0]};
          `PDS_OFF_SS0_CTRL: prdata <= {14'h0000, ss_q[0][17:0]};
          `PDS_OFF_SS1_CTRL: prdata <= {14'h0000, ss_q[1][17:0]};
          `PDS_OFF_SS0_PROF_LO: prdata <= prof_q[0][31:0];
          `PDS_OFF_SS0_PROF_HI: prdata <= {16'h0000, prof_q[0][47:32]};
          `PDS_OFF_SS1_PROF_LO: prdata <= prof_q[1][31:0];
          `PDS_OFF_SS1_PROF_HI: prdata <= {16'h0000, prof_q[1][47:32]};
          `PDS_OFF_STATUS: prdata <= {26'h0000000, status_w};
          `PDS_OFF_MULT0: prdata <= {2'h0, loop0_mult_int, 8'h00, loop0_mult_frac};
          `PDS_OFF_MULT1: prdata <= {2'h0, loop1_mult_int, 8'h00, loop1_mult_frac};
          default: begin
            if (is_bank) begin
              prdata <= {14'h0000, bank_q[bank_idx][17:16], 6'h00, bank_q[bank_idx][9:0]};
            end else begin
              prdata <= 32'h00000000;
            end
          end
        endcase
      end
      if (do_acc & pwrite) begin
        case (paddr)
          `PDS_OFF_LOOP0_FB: fb_q[0] <= pwdata;
          `PDS_OFF_LOOP1_FB: fb_q[1] <= pwdata;
          `PDS_OFF_LOOP2_FB: fb_q[2] <= pwdata;
          `PDS_OFF_SS0_CTRL: ss_q[0] <= pwdata;
          `PDS_OFF_SS1_CTRL: ss_q[1] <= pwdata;
          `PDS_OFF_SS0_PROF_LO: prof_q[0][31:0] <= pwdata;
          `PDS_OFF_SS0_PROF_HI: prof_q[0][47:32] <= pwdata[15:0];
          `PDS_OFF_SS1_PROF_LO: prof_q[1][31:0] <= pwdata;
          `PDS_OFF_SS1_PROF_HI: prof_q[1][47:32] <= pwdata[15:0];
          default: begin
            if (is_bank) begin
              bank_q[bank_idx] <= pwdata;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Spread-spectrum modulators for loops one and two
  // ----------------------------------------------------------------
  reg [7:0] lfsr_q;
  wire [1:0] ss_on;
  wire [1:0] frac_mode;
  wire [13:0] mint [0:1];
  wire [7:0] mfrac [0:1];

  // Dither source shared by both loops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr_q <= `PDS_LFSR_SEED;
    end else begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_mod
      reg [4:0] step_cnt_q;
      reg [3:0] samp_q;
      reg [1:0] quad_q;
      reg [7:0] acc_q;
      reg [7:0] frac_d;
      wire [3:0] step_code = ss_q[g][`PDS_SS_STEP_LSB +: 4];
      wire [3:0] quad_code = ss_q[g][`PDS_SS_QUAD_LSB +: 4];
      wire [5:0] offset = ss_q[g][`PDS_SS_OFFSET_LSB +: 6];
      wire dither = ss_q[g][`PDS_SS_DITHER_BIT];
      wire dbl = ss_q[g][`PDS_SS_DOUBLE_BIT];
      wire [3:0] nsamp = {quad_code[2:0], 1'b0};
      wire [4:0] step_len = {1'b0, step_code} + `PDS_STEP_EXTRA;
      wire prof_zero = (delta_sum(prof_q[g], nsamp) == 8'h00);
      wire active = (step_code != 4'h0) & ~prof_zero;
      wire fractional = (step_code != 4'h0) & prof_zero;
      // Odd quadrants walk the samples backwards to mirror the waveform
      wire [3:0] idx = quad_q[0] ? (nsamp - 4'h1 - samp_q) : samp_q;
      wire [3:0] dval = nib(prof_q[g], idx);
      wire [7:0] dstep = dbl ? {3'h0, dval, 1'b0} : {4'h0, dval};
      wire [13:0] base = int_mult(fb_q[g][`PDS_FB_COUNT_LSB +: 12],
                                  fb_q[g][`PDS_FB_ADJ_LSB +: 4]);

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          step_cnt_q <= 5'h00;
          samp_q <= 4'h0;
          quad_q <= 2'h0;
          acc_q <= 8'h00;
        end else if (!active) begin
          // Leaving the active state restarts the waveform from the offset
          step_cnt_q <= 5'h00;
          samp_q <= 4'h0;
          quad_q <= 2'h0;
          acc_q <= 8'h00;
        end else if (step_cnt_q >= step_len - 5'h01) begin
          step_cnt_q <= 5'h00;
          // Even quadrants add deltas, odd ones remove them
          if (quad_q[0]) begin
            acc_q <= acc_q - dstep;
          end else begin
            acc_q <= acc_q + dstep;
          end
          if (samp_q >= nsamp - 4'h1) begin
            samp_q <= 4'h0;
            quad_q <= quad_q + 2'h1;
          end else begin
            samp_q <= samp_q + 4'h1;
          end
        end else begin
          step_cnt_q <= step_cnt_q + 5'h01;
        end
      end

      // Waveform sample, signed about the offset; lower half negated
      // Fractional mode ignores the step, profile and dither settings
      always @* begin
        frac_d = 8'h00;
        if (fractional) begin
          frac_d = {2'h0, offset};
        end else if (active) begin
          if (quad_q[1]) begin
            frac_d = {2'h0, offset} - acc_q;
          end else begin
            frac_d = {2'h0, offset} + acc_q;
          end
          if (dither) begin
            frac_d[0] = frac_d[0] ^ lfsr_q[g];
          end
        end
      end
      assign ss_on[g] = active;
      assign frac_mode[g] = fractional;
      assign mint[g] = base;
      assign mfrac[g] = frac_d;
    end
  endgenerate

  always @* begin
    status_w = {frac_mode, ss_on, 2'h0};
  end

  // ----------------------------------------------------------------
  // Multiplier outputs, all registered
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loop0_mult_int <= 14'h0000;
      loop1_mult_int <= 14'h0000;
      loop2_mult_int <= 12'h000;
      loop0_mult_frac <= 8'h00;
      loop1_mult_frac <= 8'h00;
      loop_vco_min <= 3'h7;
    end else begin
      loop0_mult_int <= mint[0];
      loop1_mult_int <= mint[1];
      loop2_mult_int <= fb_q[2][11:0];
      loop0_mult_frac <= mfrac[0];
      loop1_mult_frac <= mfrac[1];
      loop_vco_min <= {fb_q[2][11:0] == 12'h000, fb_q[1][11:0] == 12'h000,
                       fb_q[0][11:0] == 12'h000};
    end
  end

  // ----------------------------------------------------------------
  // Post-dividers for banks two to six; first bank bypasses this block
  // ----------------------------------------------------------------
  reg [2:0] sync_q [0:4];
  reg [10:0] pcnt_q [0:4];
  reg [4:0] pclk_q;
  // Filtered level of each bank source; resets to the idle low level
  reg [4:0] lvl_q;
  integer b;
  // Banks are sampled with three flops; a change counts once two stages agree.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (b = 0; b < 5; b = b + 1) begin
        sync_q[b] <= 3'h0;
        pcnt_q[b] <= 11'h000;
      end
      pclk_q <= 5'h00;
      lvl_q <= 5'h00;
      bank_clk_out <= 5'h00;
      bank_powered <= 5'h1F;
    end else begin
      bank_powered <= 5'h1F;
      for (b = 0; b < 5; b = b + 1) begin
        sync_q[b] <= {sync_q[b][1:0], bank_clk_in[b]};
        // A change counts only once the second and third stages agree
        if (sync_q[b][1] == sync_q[b][2]) begin
          lvl_q[b] <= sync_q[b][2];
        end
        // Rising edge of the agreed input level
        if (sync_q[b][1] & sync_q[b][2] & ~lvl_q[b]) begin
          case (bank_q[b][`PDS_BK_SEL_LSB +: 2])
            `PDS_PDS_OFF: begin
              pclk_q[b] <= 1'b0;
            end
            `PDS_PDS_DIV1: begin
              pclk_q[b] <= ~pclk_q[b];
            end
            `PDS_PDS_DIV2: begin
              pcnt_q[b] <= pcnt_q[b] + 11'h001;
              if (pcnt_q[b][0]) begin
                pclk_q[b] <= ~pclk_q[b];
              end
            end
            `PDS_PDS_CNT: begin
              if (pcnt_q[b] >= {1'b0, bank_q[b][9:0]} + `PDS_POST_EXTRA - 11'h001) begin
                pcnt_q[b] <= 11'h000;
                pclk_q[b] <= ~pclk_q[b];
              end else begin
                pcnt_q[b] <= pcnt_q[b] + 11'h001;
              end
            end
            default: pclk_q[b] <= 1'b0;
          endcase
        end
        // Toggle per post-divided period: one toggle per event is the fixed halving
        bank_clk_out[b] <= pclk_q[b];
      end
    end
  end

endmodule

// ===== bench/pds_checker_assertions.sv
// Concurrent checks on the ports of the divider and modulator block
`timescale 1ns/1ps
module pds_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [4:0] bank_powered,
  input wire [11:0] loop2_mult_int,
  input wire [2:0] loop_vco_min
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Helper: last count written to loop three
  // ----------------------------------------
  reg [11:0] n2_q;
  wire wr2 = psel && penable && pready && pwrite && paddr == 12'h008;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) n2_q <= 12'h000;
    else if (wr2) n2_q <= pwdata[11:0];
  end
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_answer_bound: assert property (psel && penable && !pready |-> ##[1:2] pready)
    else $error("access not answered in time");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_hold: assert property ($fell(pready) && !psel |-> $stable(prdata))
    else $error("read data dropped early");
  a_bank_powered: assert property (bank_powered == 5'h1F)
    else $error("bank lost power");
  a_zero_count_min: assert property (loop_vco_min[2] == (loop2_mult_int == 12'h000))
    else $error("minimum flag disagrees with count");
  a_loop2_update: assert property (wr2 |-> ##[1:3] loop2_mult_int == n2_q)
    else $error("loop three multiplier not updated");
  c_write: cover property (wr2);
  c_error: cover property (pslverr);
  c_read: cover property (pready && !pwrite);
endmodule
bind pds_top pds_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .bank_powered(bank_powered),
  .loop2_mult_int(loop2_mult_int), .loop_vco_min(loop_vco_min));

// ===== bench/test_pll_divider_spread_modulator.sv
// Self-checking bench for the divider and modulator block
`timescale 1ns/1ps
`include "pds_defines.vh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module test_pll_divider_spread_modulator;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0;
  reg [4:0] bank_clk_in = 0;
  wire [31:0] prdata;
  wire pready, pslverr;
  wire [4:0] bank_clk_out, bank_powered;
  wire [13:0] loop0_mult_int, loop1_mult_int;
  wire [11:0] loop2_mult_int;
  wire [7:0] loop0_mult_frac, loop1_mult_frac;
  wire [2:0] loop_vco_min;
  integer mismatches = 0, n_tests = 0, odd, m, t[0:4];
  reg [31:0] rd;
  reg er;
  reg [7:0] mx, mn;
  reg [4:0] prev;
  pds_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bank_clk_in(bank_clk_in), .bank_clk_out(bank_clk_out),
    .bank_powered(bank_powered), .loop0_mult_int(loop0_mult_int),
    .loop1_mult_int(loop1_mult_int), .loop2_mult_int(loop2_mult_int),
    .loop0_mult_frac(loop0_mult_frac), .loop1_mult_frac(loop1_mult_frac),
    .loop_vco_min(loop_vco_min));
  initial forever #50 pclk = ~pclk;
  // Slow bank sources so the three-flop synchronisers never miss an edge
  always begin
    repeat (4) @(posedge pclk);
    bank_clk_in <= ~bank_clk_in;
  end
  task finish_test;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task apb(input reg w, input [11:0] a, input [31:0] d);
    integer k;
    begin
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      k = 0;
      while (pready !== 1'b1 && k < 20) begin
        @(posedge pclk);
        k = k + 1;
      end
      if (pready !== 1'b1) begin
        mismatches++;
        finish_test;
      end
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
    end
  endtask
  // Tracks the swing of the first loop's fraction over two full periods
  task sweep;
    begin
      mx = 8'h00;
      mn = 8'hFF;
      odd = 0;
      repeat (112) begin
        @(posedge pclk);
        if (loop0_mult_frac > mx) mx = loop0_mult_frac;
        if (loop0_mult_frac < mn) mn = loop0_mult_frac;
        if (loop0_mult_frac[0]) odd = odd + 1;
      end
    end
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    `CHK("vco min", 3'h7, loop_vco_min)
    `CHK("powered", 5'h1F, bank_powered)
    apb(1, `PDS_OFF_LOOP0_FB, 32'h00020010);
    apb(1, `PDS_OFF_LOOP1_FB, 32'h000F0FFF);
    apb(1, `PDS_OFF_LOOP2_FB, 32'h00000064);
    repeat (3) @(posedge pclk);
    `CHK("m0 odd", 14'h0023, loop0_mult_int)
    `CHK("m1 max", 14'h200E, loop1_mult_int)
    `CHK("m2", 12'h064, loop2_mult_int)
    `CHK("vco min", 3'h0, loop_vco_min)
    apb(1, `PDS_OFF_LOOP0_FB, 32'h00000005);
    repeat (3) @(posedge pclk);
    `CHK("m0 even", 14'h000A, loop0_mult_int)
    apb(0, `PDS_OFF_LOOP0_FB, 32'h0);
    `CHK("fb read", 32'h00000005, rd)
    apb(0, 12'h0FC, 32'h0);
    `CHK("unmapped err", 1'b1, er)
    `CHK("unmapped data", 32'h0, rd)
    apb(1, `PDS_OFF_LOOP0_FB, 32'h00020010);
    // Banks 0..4 get off, div1, div2, count+2 with counts 1 and 2
    for (m = 0; m < 5; m++) begin
      apb(1, `PDS_OFF_BANK_BASE + 4 * m, {14'h0, (m > 2) ? 2'h3 : m[1:0], 6'h0,
        (m > 2) ? m[9:0] - 10'h2 : 10'h0});
      t[m] = 0;
    end
    repeat (8) @(posedge pclk);
    prev = bank_clk_out;
    repeat (384) begin
      @(posedge pclk);
      for (m = 0; m < 5; m++) if (bank_clk_out[m] !== prev[m]) t[m]++;
      prev = bank_clk_out;
    end
    `CHK("bank off", 0, t[0])
    `CHK("div1", 1'b1, t[1] >= 47 && t[1] <= 49)
    `CHK("div2", 1'b1, t[2] >= 23 && t[2] <= 25)
    `CHK("q1", 1'b1, t[3] >= 15 && t[3] <= 17)
    `CHK("q2", 1'b1, t[4] >= 11 && t[4] <= 13)
    apb(1, `PDS_OFF_SS0_PROF_LO, 32'h00000021);
    apb(1, `PDS_OFF_SS0_CTRL, 32'h00000815);
    sweep;
    `CHK("peak", 8'h0B, mx)
    `CHK("trough", 8'h05, mn)
    apb(0, `PDS_OFF_STATUS, 32'h0);
    `CHK("modulating", 1'b1, rd[2])
    // A zero step code stops the modulator, so the next run starts from the offset
    apb(1, `PDS_OFF_SS0_CTRL, 32'h0);
    apb(0, `PDS_OFF_STATUS, 32'h0);
    `CHK("spread off", 2'h0, {rd[4], rd[2]})
    apb(1, `PDS_OFF_SS0_CTRL, 32'h00020815);
    sweep;
    `CHK("double peak", 8'h0E, mx)
    `CHK("double trough", 8'h02, mn)
    // Even undithered samples: any odd value comes from the dither bit
    apb(1, `PDS_OFF_SS0_CTRL, 32'h0);
    apb(1, `PDS_OFF_SS0_PROF_LO, 32'h00000022);
    apb(1, `PDS_OFF_SS0_CTRL, 32'h00010815);
    sweep;
    `CHK("dither odd", 1'b1, odd > 0)
    `CHK("dither peak", 1'b1, mx <= 8'h0D && mn >= 8'h04)
    apb(1, `PDS_OFF_SS0_PROF_LO, 32'h0);
    sweep;
    `CHK("frac hold", 16'h0808, {mx, mn})
    apb(0, `PDS_OFF_STATUS, 32'h0);
    `CHK("frac mode", 2'h2, {rd[4], rd[2]})
    finish_test;
  end
endmodule
